/* rtl/io_rec_pkg.sv */
// Shared constants for the run-time I/O parameter record loader
package io_rec_pkg;
    localparam int N_CH = 16;
    localparam int CFG_W = 16;
    localparam int REC_W = 8;
    // Record numbers
    localparam logic [7:0] DI_FIRST = 8'h00;
    localparam logic [7:0] DI_LAST = 8'h0F;
    localparam logic [7:0] DO_FIRST = 8'h40;
    localparam logic [7:0] DO_LAST = 8'h4F;
    localparam logic [7:0] CNT_REC = 8'h80;
    // Digital channel record layout
    localparam logic [7:0] DIG_REC_LEN = 8'h04;
    localparam int B_FIX0 = 0;
    localparam int B_FIX1 = 1;
    localparam int B_OPT0 = 2;
    localparam int B_OPT1 = 3;
    localparam int DLY_LSB = 0;
    localparam int DLY_W = 4;
    localparam int LIM_LSB = 8;
    localparam int LIM_W = 2;
    localparam int ISO_DELAY_US_X100 = 5;
    localparam logic [DLY_W-1:0] DLY_ISO_CODE = 4'h1;
    // Counter record layout
    localparam int B_VER = 0;
    localparam int B_PLEN = 1;
    localparam int B_RSV_A = 2;
    localparam int B_RSV_B = 3;
    localparam int B_MODE = 4;
    localparam int B_BASIC = 5;
    localparam logic [7:0] CNT_MIN_LEN = 8'h06;
    localparam logic [7:0] CNT_VER = 8'h10;
    localparam logic [7:0] CNT_PLEN = 8'h30;
    localparam logic [7:0] MODE_RSVD_MASK = 8'hF0;
    localparam logic [7:0] BASIC_RSVD_MASK = 8'hF8;
    localparam int DIAG_BIT = 2;
    localparam int STOP_LSB = 0;
    typedef enum logic [3:0] {
        MODE_OFF = 4'h0,
        MODE_COUNT = 4'h1,
        MODE_MEASURE = 4'h2
    } cnt_mode_e;
    typedef enum logic [1:0] {
        STOP_SUBST = 2'h0,
        STOP_HOLD = 2'h1,
        STOP_CONT = 2'h2,
        STOP_RSVD = 2'h3
    } stop_react_e;
    // Status words
    localparam logic [15:0] ST_ERR_RECORD = 16'h80B0;
    localparam logic [15:0] ST_ERR_LEN = 16'h80B1;
    localparam logic [15:0] ST_ERR_HDR = 16'h80B2;
    localparam logic [15:0] ST_ERR_PLAUS = 16'h80B3;
    localparam logic [15:0] ST_ERR_RUN = 16'h80B4;
    localparam logic [15:0] ST_OK = 16'h0000;
endpackage : io_rec_pkg

/* rtl/rec_if.sv */
// Carrier of one completed record from collector to consumers
`timescale 1ns/1ps
interface rec_if #(parameter int KEEP = 8);
    logic done;
    logic [7:0] index;
    logic [7:0] len;
    logic [KEEP*8-1:0] bytes;
    modport src (output done, output index, output len, output bytes);
    modport dst (input done, input index, input len, input bytes);
endinterface : rec_if

/* rtl/rec_collect.sv */
// Gathers the bytes of one record write and signals its completion
`timescale 1ns/1ps
module rec_collect #(
    parameter int KEEP = 8
) (
    input wire logic i_core_clk, // Core clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_start, // Opens a record transfer
    input wire logic [7:0] i_index, // Record number
    input wire logic i_valid, // Data byte valid
    input wire logic [7:0] i_byte, // Data byte
    input wire logic i_last, // Final byte of the record
    output logic o_busy, // Transfer open
    rec_if.src rif // Completed record
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [7:0] index;
        logic [7:0] len;
        logic [KEEP*8-1:0] bytes;
    } coll_s;

    coll_s r_reg;
    coll_s r_next;

    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        if (i_start) begin
            // A new start abandons any open transfer
            r_next.busy = 1'b1;
            r_next.index = i_index;
            r_next.len = '0;
            r_next.bytes = '0;
        end else if (r_reg.busy && i_valid) begin
            for (int k = 0; k < KEEP; k++) begin
                if (r_reg.len == 8'(k)) begin
                    r_next.bytes[k*8 +: 8] = i_byte;
                end
            end
            if (r_reg.len != 8'hFF) begin
                r_next.len = r_reg.len + 8'h01;
            end
            if (i_last) begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_busy = r_reg.busy;
    assign rif.done = r_reg.done;
    assign rif.index = r_reg.index;
    assign rif.len = r_reg.len;
    assign rif.bytes = r_reg.bytes;
endmodule : rec_collect

/* rtl/cnt_rec_check.sv */
// Validates a completed fast counter record against the live configuration
`timescale 1ns/1ps
module cnt_rec_check #(
    parameter int KEEP = 8
) (
    input wire logic i_run, // Controller running
    input wire logic [3:0] i_cur_mode, // Active operating mode
    rec_if.dst rif, // Completed record
    output logic [15:0] o_code, // ST_OK or error word
    output logic [3:0] o_mode, // Decoded operating mode
    output logic [1:0] o_stop, // Decoded stop reaction
    output logic o_diag // Decoded diagnostic enable
);
    logic [7:0] b_ver;
    logic [7:0] b_plen;
    logic [7:0] b_rsv_a;
    logic [7:0] b_rsv_b;
    logic [7:0] b_mode;
    logic [7:0] b_basic;

    assign b_ver = rif.bytes[io_rec_pkg::B_VER*8 +: 8];
    assign b_plen = rif.bytes[io_rec_pkg::B_PLEN*8 +: 8];
    assign b_rsv_a = rif.bytes[io_rec_pkg::B_RSV_A*8 +: 8];
    assign b_rsv_b = rif.bytes[io_rec_pkg::B_RSV_B*8 +: 8];
    assign b_mode = rif.bytes[io_rec_pkg::B_MODE*8 +: 8];
    assign b_basic = rif.bytes[io_rec_pkg::B_BASIC*8 +: 8];
    assign o_mode = b_mode[3:0];
    assign o_stop = b_basic[io_rec_pkg::STOP_LSB +: 2];
    assign o_diag = b_basic[io_rec_pkg::DIAG_BIT];

    always_comb begin
        o_code = io_rec_pkg::ST_OK;
        if (rif.len < io_rec_pkg::CNT_MIN_LEN) begin
            o_code = io_rec_pkg::ST_ERR_LEN;
        end else if (b_ver != io_rec_pkg::CNT_VER || b_plen != io_rec_pkg::CNT_PLEN) begin
            o_code = io_rec_pkg::ST_ERR_HDR;
        end else if ((b_rsv_a | b_rsv_b) != 8'h00
                     || (b_mode & io_rec_pkg::MODE_RSVD_MASK) != 8'h00
                     || (b_basic & io_rec_pkg::BASIC_RSVD_MASK) != 8'h00) begin
            o_code = io_rec_pkg::ST_ERR_PLAUS;
        end else if (o_mode > io_rec_pkg::MODE_MEASURE) begin
            o_code = io_rec_pkg::ST_ERR_PLAUS;
        end else if (o_stop == io_rec_pkg::STOP_RSVD) begin
            o_code = io_rec_pkg::ST_ERR_PLAUS;
        end else if (i_run && o_mode != i_cur_mode) begin
            o_code = io_rec_pkg::ST_ERR_RUN;
        end
    end
endmodule : cnt_rec_check

/* rtl/io_param_record_loader.sv */
// Top of the run-time parameter record loader for on-board digital I/O and fast counter
`timescale 1ns/1ps
// What this block does
// - Records 0 to 15 configure input channels
// - Records 64 to 79 configure output channels
// - Option bit one enables, zero disables
// - Check record only after its transfer completes
// - Failed channel record keeps prior configuration, errors
// - Rewriting one channel leaves others untouched
// - Restart restores the engineering configuration
// - Isochronous mode forces input delay 0.05 us
// - Limit enables need an assigned handler block
// - Record 128 configures the fast counter
// - Failed counter record keeps previous configuration, errors
// - Good counter record reports transferred length
// - Mode change while running is rejected
// - Extra diagnostics only when enable bit set
module io_param_record_loader #(
    parameter int KEEP = 8,
    parameter logic [7:0] DI_FIX0 = 8'h00,
    parameter logic [7:0] DI_FIX1 = 8'h00,
    parameter logic [7:0] DO_FIX0 = 8'h00,
    parameter logic [7:0] DO_FIX1 = 8'h00,
    parameter logic [15:0] DI_ENG_CFG = 16'h0000,
    parameter logic [15:0] DO_ENG_CFG = 16'h0000,
    parameter logic [3:0] ENG_CNT_MODE = 4'h0,
    parameter logic [1:0] ENG_CNT_STOP = 2'h0,
    parameter logic ENG_CNT_DIAG = 1'b0
) (
    input wire logic i_core_clk, // Core clock, 200 MHz
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_run, // Controller in running state
    input wire logic i_isochronous, // Isochronous operation active
    input wire logic [15:0] i_irq_handler_assigned, // Handler block per input channel
    input wire logic i_rec_start, // Opens a write_record_request
    input wire logic [7:0] i_rec_index, // Record number with the start
    input wire logic i_rec_valid, // Record byte valid
    input wire logic [7:0] i_rec_byte, // Record byte
    input wire logic i_rec_last, // Final record byte
    input wire logic [2:0] i_diag_event, // Supply, A/B ratio, lost interrupt
    output logic o_busy, // Record transfer open
    output logic o_status_valid, // Status pulse
    output logic o_status_error, // Status is an error word
    output logic [15:0] o_status_value, // Length or error word
    output logic [255:0] o_di_cfg, // Effective input channel options
    output logic [255:0] o_do_cfg, // Output channel options
    output logic [3:0] o_cnt_mode, // Fast counter operating mode
    output logic [1:0] o_cnt_stop_reaction, // Fast counter stop reaction
    output logic o_cnt_diag_en, // Extra diagnostics enabled
    output logic [2:0] o_diag_raise // Diagnostics passed on
);
    localparam int N = io_rec_pkg::N_CH;
    localparam int W = io_rec_pkg::CFG_W;

    if (KEEP < 6 || KEEP > 32) begin : g_keep_check
        $error("KEEP must lie between 6 and 32");
    end
    if (N * W != 256) begin : g_width_check
        $error("Channel configuration width mismatch");
    end

    typedef enum logic [3:0] {
        REC_DI = 4'b0001,
        REC_DO = 4'b0010,
        REC_CNT = 4'b0100,
        REC_NONE = 4'b1000
    } rec_class_e;

    typedef struct packed {
        logic [N-1:0][W-1:0] di_raw;
        logic [N-1:0][W-1:0] di_eff;
        logic [N-1:0][W-1:0] do_cfg;
        logic [3:0] cnt_mode;
        logic [1:0] cnt_stop;
        logic cnt_diag;
        logic st_valid;
        logic st_error;
        logic [15:0] st_value;
        logic [2:0] diag_raise;
    } loader_s;

    loader_s r_reg;
    loader_s r_next;
    rec_class_e rec_class;
    logic [15:0] cnt_code;
    logic [3:0] cnt_mode_dec;
    logic [1:0] cnt_stop_dec;
    logic cnt_diag_dec;
    logic [7:0] fix0;
    logic [7:0] fix1;
    logic [W-1:0] opt_word;
    logic [3:0] ch;

    rec_if #(.KEEP(KEEP)) rif ();

    rec_collect #(.KEEP(KEEP)) u_collect (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_start(i_rec_start),
        .i_index(i_rec_index),
        .i_valid(i_rec_valid),
        .i_byte(i_rec_byte),
        .i_last(i_rec_last),
        .o_busy(o_busy),
        .rif(rif)
    );

    cnt_rec_check #(.KEEP(KEEP)) u_cnt_check (
        .i_run(i_run),
        .i_cur_mode(r_reg.cnt_mode),
        .rif(rif),
        .o_code(cnt_code),
        .o_mode(cnt_mode_dec),
        .o_stop(cnt_stop_dec),
        .o_diag(cnt_diag_dec)
    );

    // Record number to target class
    always_comb begin
        if (rif.index <= io_rec_pkg::DI_LAST) begin
            rec_class = REC_DI;
        end else if (rif.index >= io_rec_pkg::DO_FIRST && rif.index <= io_rec_pkg::DO_LAST) begin
            rec_class = REC_DO;
        end else if (rif.index == io_rec_pkg::CNT_REC) begin
            rec_class = REC_CNT;
        end else begin
            rec_class = REC_NONE;
        end
    end

    assign fix0 = rif.bytes[io_rec_pkg::B_FIX0*8 +: 8];
    assign fix1 = rif.bytes[io_rec_pkg::B_FIX1*8 +: 8];
    assign opt_word = {rif.bytes[io_rec_pkg::B_OPT1*8 +: 8], rif.bytes[io_rec_pkg::B_OPT0*8 +: 8]};
    assign ch = rif.index[3:0];

    always_comb begin
        r_next = r_reg;
        r_next.st_valid = 1'b0;
        // Evaluation waits for the whole record, never on partial bytes
        if (rif.done) begin
            r_next.st_valid = 1'b1;
            r_next.st_error = 1'b1;
            r_next.st_value = io_rec_pkg::ST_ERR_RECORD;
            unique case (rec_class)
                REC_DI: begin
                    if (rif.len != io_rec_pkg::DIG_REC_LEN) begin
                        r_next.st_value = io_rec_pkg::ST_ERR_LEN;
                    end else if (fix0 != DI_FIX0 || fix1 != DI_FIX1) begin
                        r_next.st_value = io_rec_pkg::ST_ERR_HDR;
                    end else begin
                        // Only the addressed channel changes
                        r_next.di_raw[ch] = opt_word;
                        r_next.st_error = 1'b0;
                        r_next.st_value = {8'h00, rif.len};
                    end
                end
                REC_DO: begin
                    if (rif.len != io_rec_pkg::DIG_REC_LEN) begin
                        r_next.st_value = io_rec_pkg::ST_ERR_LEN;
                    end else if (fix0 != DO_FIX0 || fix1 != DO_FIX1) begin
                        r_next.st_value = io_rec_pkg::ST_ERR_HDR;
                    end else begin
                        r_next.do_cfg[ch] = opt_word;
                        r_next.st_error = 1'b0;
                        r_next.st_value = {8'h00, rif.len};
                    end
                end
                REC_CNT: begin
                    if (cnt_code != io_rec_pkg::ST_OK) begin
                        r_next.st_value = cnt_code;
                    end else begin
                        r_next.cnt_mode = cnt_mode_dec;
                        r_next.cnt_stop = cnt_stop_dec;
                        r_next.cnt_diag = cnt_diag_dec;
                        r_next.st_error = 1'b0;
                        r_next.st_value = {8'h00, rif.len};
                    end
                end
                REC_NONE: begin
                    r_next.st_value = io_rec_pkg::ST_ERR_RECORD;
                end
            endcase
        end
        // Effective input options follow the live mode and handler assignment
        for (int i = 0; i < N; i++) begin
            r_next.di_eff[i] = r_next.di_raw[i];
            if (i_isochronous) begin
                r_next.di_eff[i][io_rec_pkg::DLY_LSB +: io_rec_pkg::DLY_W] =
                    io_rec_pkg::DLY_ISO_CODE;
            end
            if (!i_irq_handler_assigned[i]) begin
                r_next.di_eff[i][io_rec_pkg::LIM_LSB +: io_rec_pkg::LIM_W] = '0;
            end
        end
        r_next.diag_raise = i_diag_event & {3{r_next.cnt_diag}};
    end

    // Reset reloads the engineering set; run-time writes are volatile
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_reg.di_raw <= {N{DI_ENG_CFG}};
            r_reg.di_eff <= {N{DI_ENG_CFG}};
            r_reg.do_cfg <= {N{DO_ENG_CFG}};
            r_reg.cnt_mode <= ENG_CNT_MODE;
            r_reg.cnt_stop <= ENG_CNT_STOP;
            r_reg.cnt_diag <= ENG_CNT_DIAG;
            r_reg.st_valid <= 1'b0;
            r_reg.st_error <= 1'b0;
            r_reg.st_value <= io_rec_pkg::ST_OK;
            r_reg.diag_raise <= 3'h0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_status_valid = r_reg.st_valid;
    assign o_status_error = r_reg.st_error;
    assign o_status_value = r_reg.st_value;
    assign o_di_cfg = r_reg.di_eff;
    assign o_do_cfg = r_reg.do_cfg;
    assign o_cnt_mode = r_reg.cnt_mode;
    assign o_cnt_stop_reaction = r_reg.cnt_stop;
    assign o_cnt_diag_en = r_reg.cnt_diag;
    assign o_diag_raise = r_reg.diag_raise;
endmodule : io_param_record_loader

/* verif/io_param_record_loader_props.sv */
// Port-level checks on the record loader, bound to its top
`timescale 1ns/1ps
module io_param_record_loader_props (
    input wire logic i_core_clk, // Core clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_isochronous, // Isochronous mode
    input wire logic [15:0] i_irq_handler_assigned, // Handler per input
    input wire logic i_rec_start, // Record open
    input wire logic [7:0] i_rec_index, // Record number
    input wire logic i_rec_valid, // Byte strobe
    input wire logic i_rec_last, // Final byte
    input wire logic [2:0] i_diag_event, // Raw diagnostics
    input wire logic o_busy, // Transfer open
    input wire logic o_status_valid, // Status pulse
    input wire logic o_status_error, // Error flag
    input wire logic [15:0] o_status_value, // Status word
    input wire logic [255:0] o_di_cfg, // Input options
    input wire logic [255:0] o_do_cfg, // Output options
    input wire logic [3:0] o_cnt_mode, // Counter mode
    input wire logic [1:0] o_cnt_stop_reaction, // Stop reaction
    input wire logic o_cnt_diag_en, // Diagnostic enable
    input wire logic [2:0] o_diag_raise // Passed diagnostics
);
    logic take;
    logic [7:0] cur_idx;
    logic [7:0] done_idx;
    logic [7:0] cnt;
    logic [7:0] done_len;
    assign take = i_rec_valid && i_rec_last && o_busy;
    // Latched at the last byte, since the next start may come before the status
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_idx <= 8'h00;
            done_idx <= 8'h00;
            cnt <= 8'h00;
            done_len <= 8'h00;
        end else begin
            if (i_rec_start) begin
                cur_idx <= i_rec_index;
                cnt <= 8'h00;
            end else if (i_rec_valid && o_busy) begin
                cnt <= cnt + 8'h01;
            end
            if (take) begin
                done_idx <= cur_idx;
                done_len <= cnt + 8'h01;
            end
        end
    end
    function automatic logic dig_rec(input logic [7:0] r);
        return r[7:4] == 4'h0 || r[7:4] == 4'h4;
    endfunction : dig_rec
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence answer_s;
        !o_status_valid ##1 o_status_valid ##1 !o_status_valid;
    endsequence
    sequence good_s;
        o_status_valid && !o_status_error;
    endsequence
    status_timing_a: assert property (take |=> answer_s)
        else $error("status not two cycles after last byte");
    status_cause_a: assert property (o_status_valid |-> $past(take, 2))
        else $error("status without a completed record");
    unmapped_a: assert property (
        o_status_valid && !dig_rec(done_idx) && done_idx != 8'h80
        |-> o_status_error && o_status_value == 16'h80B0) else $error("unmapped record status");
    dig_len_a: assert property (
        good_s ##0 dig_rec(done_idx) |-> o_status_value == 16'h0004)
        else $error("channel record length");
    cnt_len_a: assert property (
        good_s ##0 done_idx == 8'h80 |-> o_status_value == {8'h00, done_len})
        else $error("counter record length");
    do_hold_a: assert property (
        $changed(o_do_cfg) |-> o_status_valid && !o_status_error && done_idx[7:4] == 4'h4)
        else $error("output options changed without success");
    cnt_hold_a: assert property (
        $changed({o_cnt_mode, o_cnt_stop_reaction, o_cnt_diag_en})
        |-> o_status_valid && !o_status_error && done_idx == 8'h80)
        else $error("counter setup changed without success");
    cnt_codes_a: assert property (o_cnt_mode <= 4'h2 && o_cnt_stop_reaction != 2'h3)
        else $error("reserved counter code active");
    diag_gate_a: assert property (
        $past(i_rst_n) |-> o_diag_raise == ($past(i_diag_event) & {3{o_cnt_diag_en}}))
        else $error("diagnostic gating");
    iso_delay_a: assert property (
        $past(i_rst_n) && $past(i_isochronous)
        |-> o_di_cfg[3:0] == 4'h1 && o_di_cfg[243:240] == 4'h1) else $error("delay not forced");
    limit_gate_a: assert property (
        $past(i_rst_n) && !$past(i_irq_handler_assigned[15]) |-> o_di_cfg[249:248] == 2'h0)
        else $error("limits without handler");
    busy_open_a: assert property (i_rec_start |=> o_busy)
        else $error("transfer not open after start");
endmodule : io_param_record_loader_props
bind io_param_record_loader io_param_record_loader_props u_props (.*);

/* verif/rec_writer.sv */
// Controller-side writer that issues record write requests
`timescale 1ns/1ps
module rec_writer (
    input wire logic i_core_clk, // Core clock
    output logic o_start, // Opens a record
    output logic [7:0] o_index, // Record number
    output logic o_valid, // Byte strobe
    output logic [7:0] o_byte, // Record byte
    output logic o_last // Final byte
);
    initial begin
        o_start = 1'h0;
        o_index = 8'h00;
        o_valid = 1'h0;
        o_byte = 8'h00;
        o_last = 1'h0;
    end
    // Byte k of d is record offset k; n stays within 1 to 8
    task automatic send(input logic [7:0] idx, input int n, input logic [63:0] d);
        @(negedge i_core_clk);
        o_start = 1'h1;
        o_index = idx;
        @(negedge i_core_clk);
        o_start = 1'h0;
        o_index = ~idx;
        for (int k = 0; k < n; k++) begin
            o_valid = 1'h1;
            o_byte = d[8*k+:8];
            o_last = (k == n - 1);
            @(negedge i_core_clk);
        end
        o_valid = 1'h0;
        o_last = 1'h0;
        // Released byte lane shows no stale data
        o_byte = ~o_byte;
    endtask : send
endmodule : rec_writer

/* verif/tb_io_param_record_loader.sv */
// Self-checking bench for the record loader
`timescale 1ns/1ps
module tb_io_param_record_loader;
    localparam logic [15:0] DO_ENG = 16'h0A5A;
    localparam logic [15:0] DI_ENG = 16'h0005;
    // Engineering counter setup: counting, keep last value, extra diagnostics off
    localparam logic [6:0] CNT_ENG = 7'h0A;
    logic i_core_clk, i_rst_n, i_run, i_isochronous, i_rec_start, i_rec_valid, i_rec_last;
    logic o_busy, o_status_valid, o_status_error, o_cnt_diag_en;
    logic [15:0] i_irq_handler_assigned, o_status_value;
    logic [7:0] i_rec_index, i_rec_byte;
    logic [2:0] i_diag_event, o_diag_raise;
    logic [255:0] o_di_cfg, o_do_cfg, exp_do, exp_di;
    logic [3:0] o_cnt_mode;
    logic [1:0] o_cnt_stop_reaction;
    int mismatches, samples_checked;
    rec_writer u_rec_writer (.i_core_clk(i_core_clk), .o_start(i_rec_start),
        .o_index(i_rec_index), .o_valid(i_rec_valid), .o_byte(i_rec_byte), .o_last(i_rec_last));
    io_param_record_loader #(.DI_FIX0(8'h01), .DI_FIX1(8'h02), .DO_FIX0(8'h03),
        .DO_FIX1(8'h04), .DI_ENG_CFG(DI_ENG), .DO_ENG_CFG(DO_ENG), .ENG_CNT_MODE(CNT_ENG[6:3]),
        .ENG_CNT_STOP(CNT_ENG[2:1]), .ENG_CNT_DIAG(CNT_ENG[0])) u_io_param_record_loader (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_run(i_run),
        .i_isochronous(i_isochronous), .i_irq_handler_assigned(i_irq_handler_assigned),
        .i_rec_start(i_rec_start), .i_rec_index(i_rec_index), .i_rec_valid(i_rec_valid),
        .i_rec_byte(i_rec_byte), .i_rec_last(i_rec_last), .i_diag_event(i_diag_event),
        .o_busy(o_busy), .o_status_valid(o_status_valid), .o_status_error(o_status_error),
        .o_status_value(o_status_value), .o_di_cfg(o_di_cfg), .o_do_cfg(o_do_cfg),
        .o_cnt_mode(o_cnt_mode), .o_cnt_stop_reaction(o_cnt_stop_reaction),
        .o_cnt_diag_en(o_cnt_diag_en), .o_diag_raise(o_diag_raise));
    task automatic close_out;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %0h, want %0h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [63:0] dig(input logic [7:0] f0, f1, input logic [15:0] w);
        return {32'h0000_0000, w, f1, f0};
    endfunction : dig
    function automatic logic [63:0] cnt(input logic [7:0] md, bs);
        return {16'h0000, bs, md, 16'h0000, 8'h30, 8'h10};
    endfunction : cnt
    // Error words all carry bit 15, lengths never do
    task automatic rec(input logic [7:0] idx, input int n, input logic [63:0] d,
        input logic [15:0] exp);
        int k;
        u_rec_writer.send(idx, n, d);
        k = 0;
        while (o_status_valid !== 1'h1) begin
            @(negedge i_core_clk);
            k++;
            if (k > 8) begin
                mismatches++;
                close_out();
            end
        end
        check({o_status_error, o_status_value}, {exp[15], exp});
    endtask : rec
    task automatic reset_check;
        i_rst_n = 1'h0;
        repeat (2) @(negedge i_core_clk);
        check(o_do_cfg, {16{DO_ENG}});
        check(o_di_cfg, {16{DI_ENG}});
        check({o_cnt_mode, o_cnt_stop_reaction, o_cnt_diag_en, o_status_value}, {CNT_ENG, 16'h0000});
        i_rst_n = 1'h1;
        @(negedge i_core_clk);
    endtask : reset_check
    task automatic do_channels;
        for (int n = 0; n < 16; n++) begin
            rec(8'h40 + 8'(n), 4, dig(8'h03, 8'h04, 16'h1100 + 16'(n)), 16'h0004);
            exp_do[16*n+:16] = 16'h1100 + 16'(n);
            check(o_do_cfg, exp_do);
        end
    endtask : do_channels
    task automatic di_channels;
        for (int n = 0; n < 16; n++) begin
            rec(8'(n), 4, dig(8'h01, 8'h02, 16'h0307), 16'h0004);
            exp_di[16*n+:16] = (n < 8) ? 16'h0307 : 16'h0007;
            check(o_di_cfg, exp_di);
        end
        i_isochronous = 1'h1;
        repeat (2) @(negedge i_core_clk);
        for (int n = 0; n < 16; n++) exp_di[16*n+:4] = 4'h1;
        check(o_di_cfg, exp_di);
        i_isochronous = 1'h0;
        i_irq_handler_assigned = 16'hFFFF;
        repeat (2) @(negedge i_core_clk);
        exp_di = {16{16'h0307}};
        check(o_di_cfg, exp_di);
    endtask : di_channels
    task automatic dig_errors;
        logic [7:0] bad [6];
        bad = '{8'h10, 8'h3F, 8'h50, 8'h7F, 8'h81, 8'hFF};
        rec(8'h45, 4, dig(8'h00, 8'h04, 16'hFFFF), 16'h80B2);
        rec(8'h05, 4, dig(8'h01, 8'h03, 16'hFFFF), 16'h80B2);
        rec(8'h45, 3, dig(8'h03, 8'h04, 16'hFFFF), 16'h80B1);
        rec(8'h05, 5, dig(8'h01, 8'h02, 16'hFFFF), 16'h80B1);
        foreach (bad[k]) rec(bad[k], 4, dig(8'h01, 8'h02, 16'hFFFF), 16'h80B0);
        check({o_di_cfg, o_do_cfg}, {exp_di, exp_do});
    endtask : dig_errors
    task automatic cnt_modes;
        for (int m = 0; m < 3; m++) begin
            rec(8'h80, 6, cnt(8'(m), 8'(m) | 8'h04), 16'h0006);
            check({o_cnt_mode, o_cnt_stop_reaction, o_cnt_diag_en}, {4'(m), 2'(m), 1'h1});
        end
        rec(8'h80, 8, cnt(8'h01, 8'h00), 16'h0008);
    endtask : cnt_modes
    task automatic cnt_errors;
        rec(8'h80, 5, cnt(8'h02, 8'h00), 16'h80B1);
        rec(8'h80, 6, cnt(8'h02, 8'h00) ^ 64'h0000_0000_0000_0001, 16'h80B2);
        rec(8'h80, 6, cnt(8'h02, 8'h00) ^ 64'h0000_0000_0000_0100, 16'h80B2);
        rec(8'h80, 6, cnt(8'h02, 8'h00) ^ 64'h0000_0000_0001_0000, 16'h80B3);
        rec(8'h80, 6, cnt(8'h02, 8'h00) ^ 64'h0000_0000_0100_0000, 16'h80B3);
        rec(8'h80, 6, cnt(8'h12, 8'h00), 16'h80B3);
        rec(8'h80, 6, cnt(8'h03, 8'h00), 16'h80B3);
        rec(8'h80, 6, cnt(8'h01, 8'h03), 16'h80B3);
        rec(8'h80, 6, cnt(8'h01, 8'h08), 16'h80B3);
        check({o_cnt_mode, o_cnt_stop_reaction, o_cnt_diag_en}, 7'h08);
        i_run = 1'h1;
        rec(8'h80, 6, cnt(8'h02, 8'h00), 16'h80B4);
        rec(8'h80, 6, cnt(8'h01, 8'h02), 16'h0006);
        check({o_cnt_mode, o_cnt_stop_reaction, o_cnt_diag_en}, 7'h0C);
        i_run = 1'h0;
    endtask : cnt_errors
    task automatic diag;
        for (int e = 0; e < 2; e++) begin
            rec(8'h80, 6, cnt(8'h01, e ? 8'h04 : 8'h00), 16'h0006);
            i_diag_event = 3'h7;
            repeat (2) @(negedge i_core_clk);
            check(o_diag_raise, e ? 3'h7 : 3'h0);
            i_diag_event = 3'h0;
        end
    endtask : diag
    initial begin
        i_core_clk = 1'h0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    initial begin
        mismatches = 0;
        samples_checked = 0;
        i_run = 1'h0;
        i_isochronous = 1'h0;
        i_irq_handler_assigned = 16'h00FF;
        i_diag_event = 3'h0;
        exp_do = {16{DO_ENG}};
        exp_di = {16{16'h0005}};
        reset_check();
        do_channels();
        di_channels();
        dig_errors();
        cnt_modes();
        cnt_errors();
        diag();
        reset_check();
        close_out();
    end
endmodule : tb_io_param_record_loader
